// [lvr_pkg.sv]
`default_nettype none
package lvr_pkg;
  localparam int FRAME_W = 16;
  localparam int DATA_W = 9;
  localparam int ADDR_W = 5;
  localparam int SAMPLE_W = 8;
  localparam int WR_BIT = 15;
  localparam int ADDR_LSB = 10;
  localparam int PARITY_BIT = 9;
  localparam logic [15:0] WR_MASK = 16'h8000;
  localparam logic [15:0] ADDR_MASK = 16'h7C00;
  localparam logic [15:0] DATA_MASK = 16'h01FF;
  localparam logic [4:0] ADDR_CH1_LATEST = 5'h0A;
  localparam logic [4:0] ADDR_CH1_ON = 5'h0B;
  localparam logic [4:0] ADDR_CH1_OFF = 5'h0C;
  localparam logic [4:0] ADDR_CH2_LATEST = 5'h0D;
  localparam logic [4:0] ADDR_CH2_ON = 5'h0E;
  localparam logic [4:0] ADDR_CH2_OFF = 5'h0F;
  localparam logic [4:0] ADDR_SOFT_RESET = 5'h10;
  localparam logic [8:0] SOFT_RESET_KEY = 9'h0C3;
  localparam logic [8:0] CAPTURE_RESET = 9'h000;
  // volts per code step, in millivolts
  localparam int MV_PER_CODE = 260;
  // axi register map of the host controller
  localparam logic [3:0] AXI_CMD = 4'h0;
  localparam logic [3:0] AXI_STATUS = 4'h4;
  localparam logic [3:0] AXI_RDATA = 4'h8;
  localparam int CMD_GO_BIT = 31;
  localparam int CMD_WR_BIT = 16;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    LVR_IDLE = 2'b00,
    LVR_SHIFT = 2'b01,
    LVR_DONE = 2'b10
  } lvr_state_t;
endpackage
`default_nettype wire

// [lvr_link_if.sv]
`default_nettype none
interface lvr_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport device (input sclk, input cs_n, input mosi, output miso);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface
`default_nettype wire

// [lvr_device.sv]
// The AXI4-Lite register port was left to the implementer.
`default_nettype none
// Overview of operation
// - on-phase register holds sample before dim fall
// - off-phase register holds sample before dim rise
// - one code step is 0.26 volt
// - latest bit 8 is dim level at start
// - latest bits 7-0 newest sample, both channels
// - writing 0x0C3 to reset restores defaults; here it only pulses soft_reset_pulse, captures keep their values
// - soft reset reads back as zero
// - frame bit 15 is write flag
// - address sits in bits 14 to 10
// - write data in bits 8 to 0
// - bit 9 makes whole frame odd parity
// - addresses 0x0A to 0x10 decoded as listed
// - conversions run free of dim input
module lvr_device
  import lvr_pkg::*;
#(
  parameter int NUM_CH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  lvr_link_if.device link,
  input wire logic [NUM_CH-1:0] conv_start,
  input wire logic [NUM_CH-1:0] conv_done,
  input wire logic [NUM_CH*SAMPLE_W-1:0] conv_result,
  input wire logic [NUM_CH-1:0] dim_input,
  output logic soft_reset_pulse,
  output logic parity_error
);
  ////////////////////////////////////////////////////////////////////////////
  // capture side: one latest, on-phase and off-phase word per channel
  logic [DATA_W-1:0] latest [NUM_CH];
  logic [DATA_W-1:0] on_phase [NUM_CH];
  logic [DATA_W-1:0] off_phase [NUM_CH];
  logic [NUM_CH-1:0] dim_q;
  logic [NUM_CH-1:0] dim_at_start;
  logic [NUM_CH-1:0] have_sample;
  logic [NUM_CH-1:0] dim_fell;
  logic [NUM_CH-1:0] dim_rose;

  // codes step MV_PER_CODE millivolts; the raw adc code is kept unscaled
  assign dim_fell = dim_q & ~dim_input;
  assign dim_rose = ~dim_q & dim_input;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      // previous dim level; resets to the idle low level so no false edge
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          dim_q[g] <= 1'b0;
        end else begin
          dim_q[g] <= dim_input[g];
        end
      end

      // conversions start whenever the converter likes
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          dim_at_start[g] <= 1'b0;
        end else if (conv_start[g]) begin
          dim_at_start[g] <= dim_input[g];
        end
      end

      // an edge before the first sample must not capture the reset word
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          have_sample[g] <= 1'b0;
        end else if (conv_done[g]) begin
          have_sample[g] <= 1'b1;
        end
      end

      // whole word written in one edge, reads never see a mix
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          latest[g] <= CAPTURE_RESET;
        end else if (conv_done[g]) begin
          latest[g] <= {dim_at_start[g], conv_result[g*SAMPLE_W +: SAMPLE_W]};
        end
      end

      // snapshot the last completed sample at each dim edge; bit 8 stays zero
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          on_phase[g] <= CAPTURE_RESET;
        end else if (dim_fell[g] && have_sample[g]) begin
          on_phase[g] <= {1'b0, latest[g][SAMPLE_W-1:0]};
        end
      end

      always_ff @(posedge clk) begin
        if (!rst_n) begin
          off_phase[g] <= CAPTURE_RESET;
        end else if (dim_rose[g] && have_sample[g]) begin
          off_phase[g] <= {1'b0, latest[g][SAMPLE_W-1:0]};
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // serial link: mode 0, msb first, 16 bits per frame; clock sampled by clk
  logic sclk_q;
  logic sclk_rise;
  logic sclk_fall;
  logic [3:0] bit_cnt;
  logic [FRAME_W-1:0] rx_shift;
  logic [FRAME_W-1:0] tx_shift;
  logic [FRAME_W-1:0] reply;
  logic [ADDR_W-1:0] frame_addr;
  logic [DATA_W-1:0] read_word;
  logic frame_done;
  logic frame_odd;
  logic [FRAME_W-1:0] next_frame;

  assign next_frame = {rx_shift[FRAME_W-2:0], link.mosi};
  assign sclk_rise = link.sclk && !sclk_q;
  assign sclk_fall = !link.sclk && sclk_q;
  assign frame_addr = rx_shift[ADDR_LSB +: ADDR_W];
  assign frame_odd = ^rx_shift;

  always_comb begin
    read_word = 9'h000;
    // decode of the register address
    if (frame_addr == ADDR_CH1_LATEST) begin
      read_word = latest[0];
    end else if (frame_addr == ADDR_CH1_ON) begin
      read_word = on_phase[0];
    end else if (frame_addr == ADDR_CH1_OFF) begin
      read_word = off_phase[0];
    end else if (frame_addr == ADDR_CH2_LATEST) begin
      read_word = latest[NUM_CH-1];
    end else if (frame_addr == ADDR_CH2_ON) begin
      read_word = on_phase[NUM_CH-1];
    end else if (frame_addr == ADDR_CH2_OFF) begin
      read_word = off_phase[NUM_CH-1];
    end else begin
      read_word = 9'h000; // soft reset reads as zero
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= link.sclk;
    end
  end

  // a cut frame restarts the count at the next select
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bit_cnt <= 4'h0;
    end else if (link.cs_n) begin
      bit_cnt <= 4'h0;
    end else if (sclk_rise) begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_shift <= 16'h0000;
    end else if (!link.cs_n && sclk_rise) begin
      rx_shift <= next_frame;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame_done <= 1'b0;
    end else begin
      frame_done <= !link.cs_n && sclk_rise && (bit_cnt == 4'hF);
    end
  end

  // reply of a frame is the previous frame's read data
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reply <= 16'h0000;
    end else if (frame_done) begin
      reply <= {rx_shift[FRAME_W-1:PARITY_BIT], read_word};
    end
  end

  // loaded only while deselected: the falling clock that closes a frame
  // would otherwise shift away the first bit of the fresh reply
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_shift <= 16'h0000;
    end else if (link.cs_n) begin
      tx_shift <= reply;
    end else if (sclk_fall) begin
      tx_shift <= {tx_shift[FRAME_W-2:0], 1'b0};
    end
  end
  assign link.miso = tx_shift[FRAME_W-1];

  // parity is judged once per complete frame
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      parity_error <= 1'b0;
    end else if (frame_done) begin
      parity_error <= !frame_odd;
    end
  end

  // nothing writable lives here, so the pulse tells the rest of the device;
  // a frame with bad parity never triggers it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      soft_reset_pulse <= 1'b0;
    end else begin
      soft_reset_pulse <= frame_done && frame_odd
          && rx_shift[WR_BIT]
          && (frame_addr == ADDR_SOFT_RESET)
          && (rx_shift[DATA_W-1:0] == SOFT_RESET_KEY);
    end
  end
endmodule // lvr_device
`default_nettype wire

// [lvr_host.sv]
`default_nettype none
module lvr_host
  import lvr_pkg::*;
#(
  parameter int DIV = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  lvr_link_if.host link,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  ////////////////////////////////////////////////////////////////////////////
  lvr_state_t state;
  logic [15:0] frame;
  logic [15:0] rx;
  logic [15:0] last_rx;
  logic [4:0] bits_left;
  logic [7:0] div_cnt;
  logic aw_hold;
  logic w_hold;
  logic [3:0] aw_q;
  logic [31:0] w_q;
  logic [14:0] cmd_body;
  logic [15:0] built;

  assign cmd_body = {w_q[CMD_WR_BIT], w_q[12:8], 9'h000} |
      (w_q[CMD_WR_BIT] ? {6'h00, w_q[8:0]} : 15'h0000);
  // odd parity on bit 9 of the assembled frame
  assign built = {cmd_body[14:9], ~(^cmd_body), cmd_body[8:0]};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_q <= 4'h0;
      w_q <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_q <= s_axi_wdata;
      end
      if (aw_hold && w_hold && !s_axi_bvalid) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // only a command write while idle is accepted
        s_axi_bresp <= (aw_q == AXI_CMD && state == LVR_IDLE) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready = !w_hold && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= LVR_IDLE;
      frame <= 16'h0000;
      rx <= 16'h0000;
      last_rx <= 16'h0000;
      bits_left <= 5'd0;
      div_cnt <= 8'd0;
      link.sclk <= 1'b0;
      link.cs_n <= 1'b1;
      link.mosi <= 1'b0;
    end else begin
      case (state)
        LVR_IDLE: begin
          if (aw_hold && w_hold && !s_axi_bvalid && aw_q == AXI_CMD && w_q[CMD_GO_BIT]) begin
            frame <= {built[14:0], 1'b0};
            link.mosi <= built[15];
            link.cs_n <= 1'b0;
            bits_left <= 5'd16;
            div_cnt <= 8'd0;
            state <= LVR_SHIFT;
          end
        end
        LVR_SHIFT: begin
          if (div_cnt == 8'(DIV - 1)) begin
            div_cnt <= 8'd0;
            link.sclk <= ~link.sclk;
            if (!link.sclk) begin
              rx <= {rx[14:0], link.miso};
              bits_left <= bits_left - 5'd1;
            end else if (bits_left == 5'd0) begin
              state <= LVR_DONE;
            end else begin
              link.mosi <= frame[15];
              frame <= {frame[14:0], 1'b0};
            end
          end else begin
            div_cnt <= div_cnt + 8'd1;
          end
        end
        LVR_DONE: begin
          link.cs_n <= 1'b1;
          last_rx <= rx;
          state <= LVR_IDLE;
        end
        default: state <= LVR_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr == AXI_STATUS) begin
        s_axi_rdata <= {31'h0000_0000, state != LVR_IDLE};
      end else if (s_axi_araddr == AXI_RDATA) begin
        s_axi_rdata <= {16'h0000, last_rx};
      end else if (s_axi_araddr == AXI_CMD) begin
        s_axi_rdata <= w_q;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
endmodule // lvr_host
`default_nettype wire

// [lvr_link_props.sv]
`default_nettype none
module lvr_link_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic soft_reset_pulse,
  input wire logic parity_error
);
  logic [4:0] rises;
  // counts clock rises inside the frame, cleared while deselected
  always_ff @(posedge clk) begin
    if (!rst_n || cs_n) rises <= 5'h00;
    else if ($rose(sclk)) rises <= rises + 5'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence high_phase;
    sclk [*4] ##1 !sclk;
  endsequence
  sequence low_phase;
    !sclk [*4];
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  idle_clock_low_a: assert property (cs_n |-> !sclk)
    else $error("link clock moves while deselected");
  frame_start_low_a: assert property ($fell(cs_n) |-> !sclk)
    else $error("frame opens with clock high");
  clock_high_phase_a: assert property ($rose(sclk) |-> high_phase)
    else $error("clock high phase length wrong");
  clock_low_phase_a: assert property ($fell(sclk) && !cs_n |-> low_phase)
    else $error("clock low phase length wrong");
  mosi_hold_a: assert property ($rose(sclk) |=> $stable(mosi) [*3])
    else $error("mosi moved while clock high");
  miso_hold_a: assert property (!cs_n && sclk && $past(sclk) |-> $stable(miso))
    else $error("miso moved while clock high");
  frame_bits_a: assert property ($rose(cs_n) |-> rises == 5'h10)
    else $error("frame is not sixteen bits");
  parity_clean_a: assert property (!parity_error)
    else $error("device saw even parity");
  reset_pulse_single_a: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse too long");
endmodule // lvr_link_props
`default_nettype wire

// [led_voltage_readback_regs_tb.sv]
`default_nettype none
module led_voltage_readback_regs_tb
  import lvr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
  logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, soft_reset_pulse, parity_error;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, s;
  logic [1:0] bresp, rresp, conv_start, conv_done, dim_input, bexp;
  logic [15:0] conv_result, shift, last_frame, fexp;
  logic [9:0] last_val;
  logic [34:0] rexp;
  logic [8:0] img [32];
  logic [34:0] rq [$];
  logic [1:0] bq [$];
  logic [15:0] fq [$];
  int mismatches, tests_run, cycles, pulses;
  lvr_link_if link ();
  lvr_host #(.DIV(4)) u_lvr_host (.clk(clk), .rst_n(rst_n), .link(link),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  lvr_device u_lvr_device (.clk(clk), .rst_n(rst_n), .link(link), .conv_start(conv_start),
    .conv_done(conv_done), .conv_result(conv_result), .dim_input(dim_input),
    .soft_reset_pulse(soft_reset_pulse), .parity_error(parity_error));
  lvr_link_props u_lvr_link_props (.clk(clk), .rst_n(rst_n), .sclk(link.sclk),
    .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso),
    .soft_reset_pulse(soft_reset_pulse), .parity_error(parity_error));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (mismatches == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // a stuck handshake anywhere ends here instead of hanging
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end
  always @(negedge clk) begin
    if (rst_n === 1'b1 && soft_reset_pulse === 1'b1) pulses++;
    if (rvalid === 1'b1 && rready === 1'b1) begin
      rexp = rq.pop_front();
      if (rexp[34]) `CHK({rresp, rdata}, rexp[33:0])
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      bexp = bq.pop_front();
      `CHK(bresp, bexp)
    end
  end
  always @(posedge link.sclk) if (link.cs_n === 1'b0) shift <= {shift[14:0], link.mosi};
  always @(posedge link.cs_n) begin
    if (rst_n === 1'b1) begin
      fexp = (fq.size() > 0) ? fq.pop_front() : 'x;
      `CHK(shift, fexp)
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    bit aw, w, b;
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      @(posedge clk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (!b);
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [34:0] e, output logic [31:0] d);
    bit ar, r;
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ar = arvalid & arready;
      r = rvalid;
      d = rdata;
      @(posedge clk);
      if (ar) arvalid <= 1'b0;
    end while (!r);
    rready <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [15:0] frame(logic w, logic [4:0] a, logic [8:0] d);
    logic [15:0] f;
    f = ({w, 15'h0000} & WR_MASK) | ({11'h000, a} << ADDR_LSB & ADDR_MASK);
    f = f | ({7'h00, d} & DATA_MASK & {16{w}});
    f[PARITY_BIT] = ~^f;
    return f;
  endfunction
  // reply to each frame is checked on the following one; v[9] marks "do not check"
  task automatic spi(input logic w, input logic [4:0] a, input logic [7:0] d,
                     input logic [9:0] v);
    fq.push_back(frame(w, a, {a[0], d}));
    axi_wr(AXI_CMD, {1'b1, 14'h0000, w, 3'h0, a, d}, RESP_OKAY);
    // a second go while the frame runs is refused and sends nothing
    axi_wr(AXI_CMD, {1'b1, 14'h0000, w, 3'h0, a, d}, RESP_SLVERR);
    s = 32'h0000_0001;
    while (s[0] !== 1'b0) axi_rd(AXI_STATUS, 35'h0_0000_0000, s);
    if (!last_val[9]) axi_rd(AXI_RDATA, {1'b1, RESP_OKAY, 16'h0000, last_frame[15:9],
      last_val[8:0]}, s);
    last_frame = frame(w, a, {a[0], d});
    last_val = v;
  endtask
  task automatic step(input int ch, input logic lvl);
    logic [7:0] v;
    v = 8'($urandom());
    if (!lvl && dim_input[ch]) img[11 + 3 * ch] = {1'b0, img[10 + 3 * ch][7:0]};
    if (lvl && !dim_input[ch]) img[12 + 3 * ch] = {1'b0, img[10 + 3 * ch][7:0]};
    dim_input[ch] <= lvl;
    repeat (2) @(posedge clk);
    conv_start[ch] <= 1'b1;
    @(posedge clk);
    conv_start[ch] <= 1'b0;
    conv_result[ch * 8 +: 8] <= v;
    conv_done[ch] <= 1'b1;
    @(posedge clk);
    conv_done[ch] <= 1'b0;
    img[10 + 3 * ch] = {lvl, v};
  endtask
  task automatic read_all();
    for (int a = 10; a <= 16; a++) spi(1'b0, a[4:0], 8'h00, {1'b0, img[a]});
    spi(1'b0, ADDR_SOFT_RESET, 8'h00, 10'h000);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = {8'h00, 32'h0000_0000, 4'hF};
    {conv_start, conv_done, dim_input, conv_result} = 22'h00_0000;
    last_val = 10'h200;
    foreach (img[i]) img[i] = CAPTURE_RESET;
    void'($urandom(51251));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    read_all();
    axi_rd(AXI_CMD, {1'b1, RESP_OKAY, 32'h8000_1000}, s);
    axi_rd(4'hC, {1'b1, RESP_SLVERR, 32'h0000_0000}, s);
    axi_wr(AXI_STATUS, 32'h8000_0000, RESP_SLVERR);
    for (int c = 0; c < 2; c++) begin
      step(c, 1'b1);
      step(c, 1'b0);
      step(c, 1'b1);
      step(c, 1'b1);
    end
    // read-only capture must ignore a write
    spi(1'b1, ADDR_CH1_ON, 8'($urandom()), 10'h200);
    read_all();
    spi(1'b1, ADDR_SOFT_RESET, 8'hC2, 10'h200);
    `CHK(pulses, 0)
    spi(1'b1, ADDR_SOFT_RESET, SOFT_RESET_KEY[7:0], 10'h200);
    `CHK(pulses, 1)
    read_all();
    // one more frame brings back the reply of the last read
    spi(1'b0, ADDR_SOFT_RESET, 8'h00, 10'h200);
    test_done();
  end
endmodule // led_voltage_readback_regs_tb
`default_nettype wire
